// ===== verilog/rxfc_regs.svh
// register offsets, field values, frame limits and timing counts
`ifndef RXFC_REGS_SVH
`define RXFC_REGS_SVH

// apb register byte addresses
`define CFG_ADDR 12'h000
`define MTU_ADDR 12'h004
`define STA_LO_ADDR 12'h008
`define STA_HI_ADDR 12'h00c
`define STAT_ADDR 12'h010

// reset values: length/type checking on, mtu at 1518
`define CFG_RST 10'h010
`define MTU_RST 16'h05ee

// status register bit positions
`define STAT_PEND_BIT 16
`define STAT_PAUSED_BIT 17

// frame limits in bytes
`define MIN_FRAME 16'h0040
`define MAX_UNTAG 16'h05ee
`define MAX_TAG 16'h05f2
`define LEN_MIN 16'h002e
`define TYPE_MIN 16'h0600
`define HDR_FCS 16'h0012
`define HDR_LEN 16'h000e
`define FCS_LEN 16'h0004

// field codes, lane 0 first
`define TYPE_CTRL 16'h8808
`define TYPE_VLAN 16'h8100
`define OP_PAUSE 16'h0001
`define CTRL_MC 48'h010000c28001

// fcs, reflected form
`define CRC_INIT 32'hffffffff
`define CRC_POLY 32'hedb88320
`define CRC_RESIDUE 32'hdebb20e3

// pause quantum: 512 bit times at 10 Gb/s, rounded up
`define CLK_PERIOD_PS 25000
`define QUANTUM_PS 51200
`define QUANTUM_CYC ((`QUANTUM_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// ===== verilog/rxfc_pkg.sv
// types shared by the receive check and flow control block
package rxfc_pkg;

   // one decoded word from the phy side, lane 0 first
   typedef struct packed {
      logic [63:0] data;
      logic [7:0] keep;
      logic valid;
      logic last;
      logic err;
      logic pre;
   } phy_word_s;

   // stream word toward the client
   typedef struct packed {
      logic [63:0] tdata;
      logic [7:0] tkeep;
      logic tvalid;
      logic tlast;
      logic tuser;
   } axis_s;

   // configuration word, bit 0 is fcs_pass
   typedef struct packed {
      logic simplex_rx;
      logic tx_fc_en;
      logic rx_fc_en;
      logic cust_pre;
      logic ctl_len_dis;
      logic lt_chk_en;
      logic vlan_en;
      logic mtu_en;
      logic jumbo_en;
      logic fcs_pass;
   } cfg_s;

   typedef enum logic [1:0] {rx_idle, rx_frame, rx_close} rx_state_e;

   // whole state of the block
   typedef struct packed {
      cfg_s cfg;
      logic [15:0] mtu;
      logic [47:0] sta;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      rx_state_e rxs;
      phy_word_s hold;
      logic [15:0] hbase;
      logic [15:0] cnt;
      logic [31:0] crc;
      logic err;
      logic [1:0] widx;
      logic [47:0] da;
      logic [15:0] ltype;
      logic [15:0] opcode;
      logic [15:0] pval;
      axis_s out;
      logic req_pend;
      logic [15:0] req_val;
      logic go;
      logic [15:0] go_val;
      logic [15:0] quanta;
      logic [1:0] sub;
      logic allow;
   } state_s;

endpackage

// ===== verilog/rx_frame_check_flow_control.sv
// receive frame checks, padding strip and pause flow control
`timescale 1ns/1ps
`include "rxfc_regs.svh"

module rx_frame_check_flow_control (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // decoded words from the phy side
   input wire rxfc_pkg::phy_word_s rx_in,
   // stream toward the client
   output rxfc_pkg::axis_s rx_out,
   // pause request from the client
   input wire logic pause_req,
   input wire logic [15:0] pause_val,
   // transmitter handshake
   input wire logic tx_busy,
   output logic pause_go,
   output logic [15:0] pause_go_val,
   output logic tx_allow
);

   rxfc_pkg::state_s st;
   rxfc_pkg::state_s next_st;

   // ------------------------------------------------------------
   // helper functions
   // ------------------------------------------------------------

   // byte count of a keep word
   function automatic logic [15:0] pop(input logic [7:0] k);
      logic [15:0] n;
      n = 16'h0000;
      for (int i = 0; i < 8; i++) begin
         n = n + {15'h0000, k[i]};
      end
      return n;
   endfunction

   // clear lanes at or past the byte limit
   function automatic logic [7:0] cut(input logic [7:0] k,
                                      input logic [15:0] b,
                                      input logic [15:0] l);
      logic [7:0] m;
      m = k;
      for (int i = 0; i < 8; i++) begin
         if (b + 16'(i) >= l) begin
            m[i] = 1'b0;
         end
      end
      return m;
   endfunction

   // bytewise fcs update; long chain but one word per cycle
   function automatic logic [31:0] crc_upd(input logic [31:0] c,
                                           input logic [63:0] d,
                                           input logic [7:0] k);
      logic [31:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         if (k[i]) begin
            r = r ^ {24'h000000, d[8*i +: 8]};
            for (int j = 0; j < 8; j++) begin
               r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
            end
         end
      end
      return r;
   endfunction

   // ------------------------------------------------------------
   // end of frame checks, from registered fields
   // ------------------------------------------------------------
   logic [15:0] dlen;
   logic [15:0] maxl;
   logic is_len;
   logic is_ctrl;
   logic crc_ok;
   logic da_ok;
   logic pause_ok;
   logic fc_drop;
   logic bad;

   assign dlen = st.cnt - `HDR_FCS;
   assign maxl = (st.ltype == `TYPE_VLAN && st.cfg.vlan_en) ?
                 `MAX_TAG : `MAX_UNTAG;
   assign is_len = st.ltype < `TYPE_MIN;
   assign is_ctrl = st.ltype == `TYPE_CTRL;
   assign crc_ok = st.crc == `CRC_RESIDUE;
   assign da_ok = st.da == `CTRL_MC || st.da == st.sta;
   assign pause_ok = !st.err && crc_ok && da_ok && is_ctrl &&
                     st.opcode == `OP_PAUSE && st.cnt == `MIN_FRAME;
   // disabled flow control leaves frame alone unless simplex_rx is set
   assign fc_drop = pause_ok &&
                    (st.cfg.rx_fc_en || st.cfg.simplex_rx);

   // each term one bad frame cause
   always_comb begin
      bad = 1'b0;
      bad = bad || st.err || !crc_ok;
      bad = bad || st.cnt < `MIN_FRAME;
      // oversize; an enabled mtu check replaces this ceiling
      bad = bad || (!st.cfg.jumbo_en && !st.cfg.mtu_en && st.cnt > maxl);
      bad = bad || (st.cfg.mtu_en && !st.cfg.jumbo_en &&
                    st.cnt > st.mtu);
      bad = bad || (is_ctrl && st.cnt != `MIN_FRAME &&
                    !st.cfg.ctl_len_dis);
      bad = bad || (is_len && st.ltype >= `LEN_MIN &&
                    st.cfg.lt_chk_en && dlen != st.ltype);
      bad = bad || (is_len && st.ltype < `LEN_MIN &&
                    st.cnt != `MIN_FRAME);
      bad = bad || fc_drop;
   end

   // ------------------------------------------------------------
   // byte limit for the held word
   // ------------------------------------------------------------
   logic first;
   logic dword;
   logic [15:0] base_cnt;
   logic [31:0] base_crc;
   logic [15:0] tot;
   logic known;
   logic padcut;
   logic [15:0] lim;
   logic [7:0] hkeep;
   logic hvalid;
   logic [1:0] wi;

   assign first = st.rxs == rxfc_pkg::rx_idle;
   assign dword = rx_in.valid && !rx_in.pre;
   assign base_cnt = first ? 16'h0000 : st.cnt;
   assign base_crc = first ? `CRC_INIT : st.crc;
   assign wi = first ? 2'h0 : st.widx;
   assign known = st.rxs == rxfc_pkg::rx_close ||
                  (dword && rx_in.last);
   assign tot = (st.rxs == rxfc_pkg::rx_close) ? st.cnt :
                base_cnt + pop(rx_in.keep);
   // padding removed only when lengths are checked
   assign padcut = st.cfg.lt_chk_en && st.ltype < `LEN_MIN &&
                   st.widx >= 2'h2;

   always_comb begin
      if (st.cfg.fcs_pass) begin
         lim = 16'hffff;
      end else if (padcut) begin
         lim = `HDR_LEN + st.ltype;
      end else if (known) begin
         lim = tot - `FCS_LEN;
      end else begin
         lim = 16'hffff;
      end
   end

   // preamble word framed on lanes 1 to 7
   assign hkeep = st.hold.pre ?
                  (st.cfg.cust_pre ? 8'hfe : 8'h00) :
                  cut(st.hold.keep, st.hbase, lim);
   assign hvalid = st.hold.valid &&
                   (!st.hold.pre || st.cfg.cust_pre);

   // ------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------
   logic hit;
   logic [31:0] rd;

   always_comb begin
      hit = 1'b1;
      rd = 32'h00000000;
      case (paddr)
         `CFG_ADDR: rd = {22'h000000, st.cfg};
         `MTU_ADDR: rd = {16'h0000, st.mtu};
         `STA_LO_ADDR: rd = st.sta[31:0];
         `STA_HI_ADDR: rd = {16'h0000, st.sta[47:32]};
         `STAT_ADDR: begin
            rd[15:0] = st.quanta;
            rd[`STAT_PEND_BIT] = st.req_pend;
            rd[`STAT_PAUSED_BIT] = st.quanta != 16'h0000;
         end
         default: hit = 1'b0;
      endcase
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.out.tvalid = 1'b0;
      next_st.out.tlast = 1'b0;
      next_st.out.tuser = 1'b0;
      next_st.go = 1'b0;

      // apb: answer in the first access cycle
      next_st.pready = psel && !penable;
      next_st.pslverr = psel && !penable && !hit;
      next_st.prdata = (psel && !penable && hit) ? rd : 32'h00000000;
      if (psel && penable && st.pready && pwrite) begin
         case (paddr)
            `CFG_ADDR: next_st.cfg = rxfc_pkg::cfg_s'(pwdata[9:0]);
            `MTU_ADDR: next_st.mtu = pwdata[15:0];
            `STA_LO_ADDR: next_st.sta[31:0] = pwdata;
            `STA_HI_ADDR: next_st.sta[47:32] = pwdata[15:0];
            default: next_st.mtu = st.mtu;
         endcase
      end

      if (st.quanta != 16'h0000) begin
         if (st.sub == 2'(`QUANTUM_CYC - 1)) begin
            next_st.sub = 2'h0;
            next_st.quanta = st.quanta - 16'h0001;
         end else begin
            next_st.sub = st.sub + 2'h1;
         end
      end

      // receive path; no stall, one word out per word in
      case (st.rxs)
         rxfc_pkg::rx_idle, rxfc_pkg::rx_frame: begin
            if (rx_in.valid && rx_in.pre && first) begin
               next_st.hold = rx_in;
            end else if (dword) begin
               // older word leaves as a new one arrives
               next_st.out.tvalid = hvalid;
               next_st.out.tdata = st.hold.data;
               next_st.out.tkeep = hvalid ? hkeep : 8'h00;
               next_st.hold = rx_in;
               next_st.hbase = base_cnt;
               next_st.cnt = tot;
               next_st.crc = crc_upd(base_crc, rx_in.data,
                                     rx_in.keep);
               next_st.err = (!first && st.err) || rx_in.err;
               next_st.widx = (wi == 2'h3) ? 2'h3 : wi + 2'h1;
               // header fields by word position
               case (wi)
                  2'h0: next_st.da = rx_in.data[47:0];
                  2'h1: begin
                     next_st.ltype = {rx_in.data[39:32],
                                      rx_in.data[47:40]};
                     next_st.opcode = {rx_in.data[55:48],
                                       rx_in.data[63:56]};
                  end
                  2'h2: next_st.pval = {rx_in.data[7:0],
                                        rx_in.data[15:8]};
                  default: next_st.pval = st.pval;
               endcase
               next_st.rxs = rx_in.last ? rxfc_pkg::rx_close :
                             rxfc_pkg::rx_frame;
            end
         end
         rxfc_pkg::rx_close: begin
            // status one cycle after the last word
            next_st.out.tvalid = 1'b1;
            next_st.out.tlast = 1'b1;
            next_st.out.tuser = !bad;
            next_st.out.tdata = st.hold.data;
            next_st.out.tkeep = hkeep;
            next_st.hold.valid = 1'b0;
            next_st.rxs = rxfc_pkg::rx_idle;
            if (pause_ok && st.cfg.rx_fc_en && !st.cfg.simplex_rx) begin
               next_st.quanta = st.pval;
               next_st.sub = 2'h0;
            end
         end
         default: next_st.rxs = rxfc_pkg::rx_idle;
      endcase

      // send once the transmitter is idle, even while paused
      if (st.req_pend && !tx_busy && !st.go) begin
         next_st.go = 1'b1;
         next_st.go_val = st.req_val;
         next_st.req_pend = 1'b0;
      end
      // new request wins over the clear
      if (pause_req && st.cfg.tx_fc_en) begin
         next_st.req_pend = 1'b1;
         next_st.req_val = pause_val;
      end
      // pending pause and quanta hold back client frames
      next_st.allow = next_st.quanta == 16'h0000 &&
                      !next_st.req_pend;
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   // synchronous reset to constants only
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         st <= '0;
         st.cfg <= rxfc_pkg::cfg_s'(`CFG_RST);
         st.mtu <= `MTU_RST;
         st.allow <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from the state register
   assign prdata = st.prdata;
   assign pready = st.pready;
   assign pslverr = st.pslverr;
   assign rx_out = st.out;
   assign pause_go = st.go;
   assign pause_go_val = st.go_val;
   assign tx_allow = st.allow;

endmodule // rx_frame_check_flow_control

// ===== testbench/rxfc_monitor.sv
// port assertions for the receive check and flow control block
`timescale 1ns/1ps

module rxfc_monitor (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // receive streams
   input wire rxfc_pkg::phy_word_s rx_in,
   input wire rxfc_pkg::axis_s rx_out,
   // pause handshake
   input wire logic pause_req,
   input wire logic [15:0] pause_val,
   input wire logic tx_busy,
   input wire logic pause_go,
   input wire logic [15:0] pause_go_val,
   input wire logic tx_allow
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   // ----------------------------------------
   // helper state
   // ----------------------------------------
   // last asked value; a later request overwrites it even while one is pending
   logic [15:0] req_val;
   always_ff @(posedge sys_clk) begin
      if (pause_req) begin
         req_val <= pause_val;
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   status_at_end_a: assert property (
      rx_out.tuser |-> rx_out.tlast && rx_out.tvalid)
      else $error("good flag outside end of frame");
   end_timing_a: assert property (
      rx_in.valid && rx_in.last |-> ##2 rx_out.tlast)
      else $error("end of frame late");
   end_gap_a: assert property (
      rx_out.tlast |=> !rx_out.tvalid [*2])
      else $error("words right after end of frame");
   code_err_a: assert property (
      rx_in.valid && rx_in.last && rx_in.err |-> ##2 !rx_out.tuser)
      else $error("frame with code error passed good");
   go_when_free_a: assert property (
      pause_go |-> !$past(tx_busy))
      else $error("pause frame cut into busy frame");
   go_value_a: assert property (
      pause_go |-> pause_go_val == req_val)
      else $error("pause frame value wrong");
   go_single_a: assert property (
      pause_go |=> !pause_go)
      else $error("pause go longer than a pulse");
   go_blocks_a: assert property (
      pause_go |-> !$past(tx_allow))
      else $error("frames allowed while pause pending");
   go_val_held_a: assert property (
      !pause_go |-> $stable(pause_go_val))
      else $error("pause value moved without go");
endmodule // rxfc_monitor

bind rx_frame_check_flow_control rxfc_monitor rxfc_monitor_inst (
   .sys_clk(sys_clk), .nrst(nrst), .rx_in(rx_in), .rx_out(rx_out),
   .pause_req(pause_req), .pause_val(pause_val), .tx_busy(tx_busy),
   .pause_go(pause_go), .pause_go_val(pause_go_val), .tx_allow(tx_allow));

// ===== testbench/rxfc_client_model.sv
// client logic that takes every offered word and sums up each frame
`timescale 1ns/1ps

module rxfc_client_model (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // stream from the block
   input wire rxfc_pkg::axis_s rx_out,
   // frame summary
   output logic [15:0] frames,
   output logic [15:0] bytes_kept,
   output logic good
);
   logic [15:0] acc;

   always @(posedge sys_clk) begin
      if (!nrst) begin
         frames <= 16'h0000;
         acc <= 16'h0000;
         bytes_kept <= 16'h0000;
         good <= 1'b0;
      end else if (rx_out.tvalid && rx_out.tlast) begin
         bytes_kept <= acc + 16'($countones(rx_out.tkeep));
         good <= rx_out.tuser;
         frames <= frames + 16'h0001;
         acc <= 16'h0000;
      end else if (rx_out.tvalid) begin
         acc <= acc + 16'($countones(rx_out.tkeep));
      end
   end
endmodule // rxfc_client_model

// ===== testbench/rx_frame_check_flow_control_test.sv
// self-checking bench for the receive check and flow control block
`timescale 1ns/1ps
`include "rxfc_regs.svh"

`define CHK(nm, ex, sn) begin \
   samples_checked++; \
   if ((sn) !== (ex)) begin \
      bad_count++; \
      $display("MISMATCH %s exp %0h got %0h", nm, ex, sn); \
   end \
end

module rx_frame_check_flow_control_test;
   logic sys_clk, nrst, psel, penable, pwrite, pready, pslverr, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic pause_req, tx_busy, pause_go, tx_allow, good;
   logic [15:0] pause_val, pause_go_val, frames, bytes_kept, seed;
   rxfc_pkg::phy_word_s rx_in;
   rxfc_pkg::axis_s rx_out;
   rxfc_pkg::cfg_s c;
   logic [7:0] fb[$];
   int bad_count, samples_checked, nfr;
   localparam logic [47:0] MC = `CTRL_MC;
   // preamble word ahead of each frame, destination of pause frames
   logic pw;
   logic [47:0] da_sel;

   rx_frame_check_flow_control rx_frame_check_flow_control_inst (
      .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rx_in(rx_in), .rx_out(rx_out),
      .pause_req(pause_req), .pause_val(pause_val), .tx_busy(tx_busy),
      .pause_go(pause_go), .pause_go_val(pause_go_val),
      .tx_allow(tx_allow));
   rxfc_client_model rxfc_client_model_inst (.sys_clk(sys_clk),
      .nrst(nrst), .rx_out(rx_out), .frames(frames),
      .bytes_kept(bytes_kept), .good(good));

   // 40 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   task automatic finish_test;
      if (bad_count == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic hung;
      bad_count++;
      finish_test();
   endtask

   // lfsr byte source, repeatable from the fixed seed
   function automatic logic [7:0] rb();
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      return seed[7:0];
   endfunction

   function automatic logic [31:0] crc8(input logic [31:0] k,
                                        input logic [7:0] b);
      k = k ^ {24'h000000, b};
      for (int i = 0; i < 8; i++) k = k[0] ? (k >> 1) ^ 32'hedb88320 : k >> 1;
      return k;
   endfunction

   // bytes the client should see, fcs included in fb
   function automatic logic [15:0] kb(input logic [15:0] lt);
      logic [15:0] p;
      p = (pw && c.cust_pre) ? 16'h0007 : 16'h0000;
      if (c.fcs_pass) return p + 16'(fb.size());
      if (c.lt_chk_en && lt < 16'h002e) return p + 16'h000e + lt;
      return p + 16'(fb.size() - 4);
   endfunction

   // apb master: holds the request until pready is sampled high
   task automatic apb(input logic [11:0] a, input logic w,
                      input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) hung();
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // idle cycle, so a following setup never redrives psel at once
      @(posedge sys_clk);
   endtask

   task automatic setc;
      apb(`CFG_ADDR, 1'b1, {22'h000000, c});
   endtask

   // build, send and judge one frame; op nonzero sends to da_sel with that opcode
   task automatic fr(input logic [15:0] lt, input int pl,
                     input logic [15:0] op, input logic bf,
                     input logic pe, input logic g);
      int n;
      logic [31:0] k;
      rxfc_pkg::phy_word_s w;
      fb = {};
      for (int i = 0; i < 6; i++)
         fb.push_back(op != 0 ? da_sel[8*i+:8] : rb());
      for (int i = 0; i < 6; i++) fb.push_back(rb());
      fb.push_back(lt[15:8]);
      fb.push_back(lt[7:0]);
      for (int i = 0; i < pl; i++) fb.push_back(rb());
      if (op != 0) begin
         fb[14] = op[15:8];
         fb[15] = op[7:0];
         fb[16] = 8'h00;
         fb[17] = 8'h05;
      end
      k = 32'hffffffff;
      foreach (fb[i]) k = crc8(k, fb[i]);
      k = ~k ^ {31'h00000000, bf};
      for (int i = 0; i < 4; i++) fb.push_back(k[8*i+:8]);
      n = fb.size();
      // optional preamble word ahead of the frame
      if (pw) begin
         w = '0;
         w.valid = 1'b1;
         w.pre = 1'b1;
         w.data = {rb(), rb(), rb(), rb(), rb(), rb(), rb(), 8'h00};
         rx_in <= w;
         @(posedge sys_clk);
      end
      for (int i = 0; i < n; i += 8) begin
         w = '0;
         w.valid = 1'b1;
         w.last = (i + 8 >= n);
         w.err = pe & w.last;
         for (int j = 0; j < 8 && i + j < n; j++) begin
            w.data[8*j+:8] = fb[i+j];
            w.keep[j] = 1'b1;
         end
         rx_in <= w;
         @(posedge sys_clk);
      end
      rx_in <= '0;
      nfr++;
      for (n = 0; frames !== 16'(nfr); n++) begin
         if (n > 20) hung();
         @(posedge sys_clk);
      end
      `CHK("tuser", g, good)
      `CHK("bytes", kb(lt), bytes_kept)
   endtask

   initial begin
      int n;
      logic [15:0] pv;
      logic [47:0] sa;
      nrst = 1'b0;
      pw = 1'b0;
      da_sel = MC;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {pause_req, pause_val, tx_busy} = '0;
      rx_in = '0;
      seed = 16'h001e;
      c = `CFG_RST;
      repeat (6) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      // reset values and an unmapped place
      apb(`CFG_ADDR, 1'b0, 32'h0);
      `CHK("cfg", 32'h00000010, q)
      apb(`MTU_ADDR, 1'b0, 32'h0);
      `CHK("mtu", 32'h000005ee, q)
      apb(12'h014, 1'b0, 32'h0);
      `CHK("slverr", 1'b1, e)
      fr(16'h0800, 46, 0, 0, 0, 1);
      fr(16'h0800, 46, 0, 1, 0, 0);
      fr(16'h0800, 46, 0, 0, 1, 0);
      fr(16'h0800, 42, 0, 0, 0, 0);
      fr(16'h0014, 46, 0, 0, 0, 1);
      fr(16'h0014, 48, 0, 0, 0, 0);
      fr(16'h0064, 100, 0, 0, 0, 1);
      fr(16'h0064, 104, 0, 0, 0, 0);
      fr(16'h0800, 1501, 0, 0, 0, 0);
      c.vlan_en = 1'b1;
      setc();
      fr(16'h8100, 1504, 0, 0, 0, 1);
      fr(16'h8100, 1505, 0, 0, 0, 0);
      c.jumbo_en = 1'b1;
      setc();
      fr(16'h0800, 1501, 0, 0, 0, 1);
      c.jumbo_en = 1'b0;
      c.mtu_en = 1'b1;
      setc();
      apb(`MTU_ADDR, 1'b1, 32'h00000640);
      fr(16'h0800, 1540, 0, 0, 0, 1);
      fr(16'h0800, 1590, 0, 0, 0, 0);
      c = 10'h000;
      setc();
      fr(16'h0064, 104, 0, 0, 0, 1);
      fr(16'h0014, 48, 0, 0, 0, 0);
      c.lt_chk_en = 1'b1;
      c.fcs_pass = 1'b1;
      setc();
      fr(16'h0014, 46, 0, 0, 0, 1);
      fr(16'h0014, 46, 0, 1, 0, 0);
      // preamble word dropped, then shown with lanes 1 to 7
      pw = 1'b1;
      fr(16'h0014, 46, 0, 0, 0, 1);
      c.cust_pre = 1'b1;
      setc();
      fr(16'h0800, 46, 0, 0, 0, 1);
      c.cust_pre = 1'b0;
      pw = 1'b0;
      c.fcs_pass = 1'b0;
      c.rx_fc_en = 1'b1;
      c.tx_fc_en = 1'b1;
      setc();
      fr(`TYPE_CTRL, 46, `OP_PAUSE, 0, 0, 0);
      `CHK("paused", 1'b0, tx_allow)
      apb(`STAT_ADDR, 1'b0, 32'h0);
      `CHK("paused bit", 1'b1, q[`STAT_PAUSED_BIT])
      // ask for a pause frame while paused and behind a busy frame
      pv = {rb(), rb()};
      tx_busy <= 1'b1;
      pause_val <= pv;
      pause_req <= 1'b1;
      @(posedge sys_clk);
      pause_req <= 1'b0;
      // request waits behind the busy frame
      apb(`STAT_ADDR, 1'b0, 32'h0);
      `CHK("pending bit", 1'b1, q[`STAT_PEND_BIT])
      tx_busy <= 1'b0;
      for (n = 0; pause_go !== 1'b1; n++) begin
         if (n > 10) hung();
         @(posedge sys_clk);
      end
      `CHK("go value", pv, pause_go_val)
      for (n = 0; tx_allow !== 1'b1; n++) begin
         if (n > 40) hung();
         @(posedge sys_clk);
      end
      fr(`TYPE_CTRL, 46, 16'h0002, 0, 0, 1);
      fr(`TYPE_CTRL, 50, `OP_PAUSE, 0, 0, 0);
      `CHK("not acted", 1'b1, tx_allow)
      // pause addressed to the station rather than the multicast group
      sa = {rb(), rb(), rb(), rb(), rb(), rb()};
      apb(`STA_LO_ADDR, 1'b1, sa[31:0]);
      apb(`STA_HI_ADDR, 1'b1, {16'h0000, sa[47:32]});
      da_sel = sa;
      fr(`TYPE_CTRL, 46, `OP_PAUSE, 0, 0, 0);
      `CHK("station pause", 1'b0, tx_allow)
      da_sel = MC;
      c.ctl_len_dis = 1'b1;
      setc();
      fr(`TYPE_CTRL, 50, `OP_PAUSE, 0, 0, 1);
      c.rx_fc_en = 1'b0;
      setc();
      fr(`TYPE_CTRL, 46, `OP_PAUSE, 0, 0, 1);
      c.simplex_rx = 1'b1;
      setc();
      fr(`TYPE_CTRL, 46, `OP_PAUSE, 0, 0, 0);
      `CHK("simplex", 1'b1, tx_allow)
      finish_test();
   end
endmodule // rx_frame_check_flow_control_test
